/* include/cid_host_pkg.sv */
// Constants shared by the caller-identity receiver sequencer
package cid_host_pkg;
	localparam int CLK_KHZ = 250000;
	localparam int CTL_WIDTH = 3;
	// Control input codes, decoded by the receiver
	localparam logic [2:0] CTL_POWER_DOWN = 3'h0;
	localparam logic [2:0] CTL_DEMOD = 3'h1;
	localparam logic [2:0] CTL_ALERT_HANDSET = 3'h2;
	localparam logic [2:0] CTL_ALERT_LINE = 3'h3;
	// Times in ms and the frame error count, as printed or chosen where none is printed
	localparam int RUN_LIMIT_MS = 150;
	localparam int FRAME_ERR_LIMIT = 5;
	localparam int CARRIER_DETECT_MS = 25;
	localparam int RX_TIMEOUT_MS = 500;
	localparam int WAIT_D_MS = 500;
	localparam int LOAD_HOLD_MIN_MS = 50;
	localparam int LOAD_HOLD_MAX_MS = 150;
	localparam int ABSENT_GUARD_MS = 15;
	// Cycle counts derived from the rate; 64-bit products avoid overflow
	localparam longint RUN_LIMIT_CYC = longint'(RUN_LIMIT_MS) * CLK_KHZ;
	localparam longint RX_TIMEOUT_CYC = longint'(RX_TIMEOUT_MS) * CLK_KHZ;
	localparam longint WAIT_D_CYC = longint'(WAIT_D_MS) * CLK_KHZ;
	localparam longint LOAD_HOLD_CYC = longint'(LOAD_HOLD_MIN_MS) * CLK_KHZ;
	localparam int TIMER_WIDTH = 32;
	localparam int FE_WIDTH = 3;
endpackage : cid_host_pkg

/* design/run_timer.sv */
// Cycle timer with synchronous clear and expiry flag
`timescale 1ns/100ps
module run_timer #(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Control
	input wire logic clear,
	input wire logic run,
	input wire logic [WIDTH-1:0] limit,
	// Status
	output logic expired
);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;

	// Saturates at the limit so a late clear never wraps into a false expiry
	always_comb begin
		next_count = count;
		if (clear) begin
			next_count = '0;
		end else if (run && (count < limit)) begin
			next_count = count + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	// Not gated by clear: the phase timer's caller derives its clear from this flag
	assign expired = (count >= limit);
endmodule : run_timer

/* design/caller_id_host_sequencer.sv */
// Host sequencer driving a caller-identity receiver through its control pins
// Functional notes
// - Power down after carrier flag goes inactive
// - Time out when carrier never appears
// - Exit demod: carrier off, 5 errors, 150ms run
// - Off-hook: demod only after acknowledgement tone
// - No data: unmute handset, enable keypad
// - Demod off whenever data is not expected
// - Apply load right after tone flag rises
// - Remove loads 50-150ms after carrier ends
// - Apply terminations promptly after ring ends
// - Leave demod when carrier ends, loads later
// - Keep receiver off until ringing ends
`timescale 1ns/100ps
module caller_id_host_sequencer #(
	parameter int TIMER_WIDTH = cid_host_pkg::TIMER_WIDTH,
	parameter logic [TIMER_WIDTH-1:0] RUN_LIMIT =
		TIMER_WIDTH'(cid_host_pkg::RUN_LIMIT_CYC),
	parameter logic [TIMER_WIDTH-1:0] RX_TIMEOUT =
		TIMER_WIDTH'(cid_host_pkg::RX_TIMEOUT_CYC),
	parameter logic [TIMER_WIDTH-1:0] WAIT_D =
		TIMER_WIDTH'(cid_host_pkg::WAIT_D_CYC),
	parameter logic [TIMER_WIDTH-1:0] LOAD_HOLD =
		TIMER_WIDTH'(cid_host_pkg::LOAD_HOLD_CYC),
	parameter int FRAME_ERR_LIMIT = cid_host_pkg::FRAME_ERR_LIMIT
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// User orders
	input wire logic onHookStart,
	input wire logic offHookWatch,
	input wire logic lineSideAlert,
	input wire logic displayServices,
	input wire logic ackDone,
	// Line and serial status from the user side
	input wire logic ringActive,
	input wire logic framingError,
	input wire logic serialData,
	// Receiver pins
	input wire logic carrier_present_n,
	input wire logic ready_or_tone_flag_n,
	output logic [cid_host_pkg::CTL_WIDTH-1:0] control_bits,
	// Line and handset controls
	output logic lineLoad,
	output logic handsetMute,
	output logic keypadEnable,
	output logic ackRequest,
	output logic ackDigitA,
	// Outcome
	output logic sessionDone,
	output logic attemptFailed,
	output logic busy
);
	typedef enum {
		ST_OFF,
		ST_RINGING,
		ST_ALERT_WATCH,
		ST_TONE_END,
		ST_ACK,
		ST_RX_WAIT,
		ST_RX_DATA,
		ST_LOAD_HOLD
	} state_t;

	state_t state;
	state_t next_state;
	logic [cid_host_pkg::CTL_WIDTH-1:0] next_control_bits;
	logic next_lineLoad;
	logic next_handsetMute;
	logic next_keypadEnable;
	logic next_ackRequest;
	logic next_ackDigitA;
	logic next_sessionDone;
	logic next_attemptFailed;
	logic [cid_host_pkg::FE_WIDTH-1:0] frameErrCount;
	logic [cid_host_pkg::FE_WIDTH-1:0] next_frameErrCount;
	logic lastData;
	logic lastToneFlag;
	logic phaseClear;
	logic phaseExpired;
	logic runClear;
	logic runExpired;
	logic [TIMER_WIDTH-1:0] phaseLimit;
	logic toneRise;

	localparam logic [cid_host_pkg::FE_WIDTH-1:0] FE_LAST =
		cid_host_pkg::FE_WIDTH'(FRAME_ERR_LIMIT - 1);
	localparam logic [cid_host_pkg::FE_WIDTH-1:0] FE_WIDTH_MAX =
		cid_host_pkg::FE_WIDTH'(FRAME_ERR_LIMIT);

	// Tone flag is active low; its rising edge marks tone end
	assign toneRise = ready_or_tone_flag_n && !lastToneFlag;

	// Phase timer restarts on every state change
	assign phaseClear = (next_state != state);
	// Must exceed the receiver's worst carrier delay
	assign phaseLimit = (state == ST_RX_WAIT) ?
		(displayServices ? RX_TIMEOUT : WAIT_D) : LOAD_HOLD;

	// Any bit change breaks a mark or space run
	assign runClear = (state != ST_RX_DATA) || (serialData != lastData);

	run_timer #(
		.WIDTH(TIMER_WIDTH)
	) phaseTimer (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clear(phaseClear),
		.run(1'b1),
		.limit(phaseLimit),
		.expired(phaseExpired)
	);

	run_timer #(
		.WIDTH(TIMER_WIDTH)
	) runTimer (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clear(runClear),
		.run(1'b1),
		.limit(RUN_LIMIT),
		.expired(runExpired)
	);

	always_comb begin
		next_state = state;
		next_control_bits = control_bits;
		next_lineLoad = lineLoad;
		next_handsetMute = handsetMute;
		next_keypadEnable = keypadEnable;
		next_ackRequest = 1'b0;
		next_ackDigitA = ackDigitA;
		next_sessionDone = 1'b0;
		next_attemptFailed = 1'b0;
		next_frameErrCount = frameErrCount;
		case (state)
			ST_OFF: begin
				next_control_bits = cid_host_pkg::CTL_POWER_DOWN;
				if (onHookStart) begin
					next_state = ST_RINGING;
				end else if (offHookWatch) begin
					next_state = ST_ALERT_WATCH;
					next_control_bits = lineSideAlert ?
						cid_host_pkg::CTL_ALERT_LINE :
						cid_host_pkg::CTL_ALERT_HANDSET;
				end
			end
			ST_RINGING: begin
				// Carrier flag is ignored here; ringing cannot raise it
				if (!ringActive) begin
					next_state = ST_RX_WAIT;
					next_lineLoad = 1'b1;
					next_control_bits = cid_host_pkg::CTL_DEMOD;
					next_frameErrCount = '0;
				end
			end
			ST_ALERT_WATCH: begin
				// Flag falls only after guard plus detect time
				if (!ready_or_tone_flag_n) begin
					next_state = ST_TONE_END;
					next_handsetMute = 1'b1;
					next_keypadEnable = 1'b0;
				end
			end
			ST_TONE_END: begin
				if (toneRise) begin
					next_state = ST_ACK;
					next_lineLoad = 1'b1;
					next_ackRequest = 1'b1;
					next_ackDigitA = displayServices;
					next_control_bits = cid_host_pkg::CTL_POWER_DOWN;
				end
			end
			ST_ACK: begin
				if (ackDone) begin
					next_state = ST_RX_WAIT;
					next_control_bits = cid_host_pkg::CTL_DEMOD;
					next_frameErrCount = '0;
				end
			end
			ST_RX_WAIT: begin
				if (!carrier_present_n) begin
					next_state = ST_RX_DATA;
				end else if (phaseExpired) begin
					next_state = ST_OFF;
					next_control_bits = cid_host_pkg::CTL_POWER_DOWN;
					next_lineLoad = 1'b0;
					next_handsetMute = 1'b0;
					next_keypadEnable = 1'b1;
					next_attemptFailed = 1'b1;
				end
			end
			ST_RX_DATA: begin
				if (framingError &&
					(frameErrCount < FE_WIDTH_MAX)) begin
					next_frameErrCount = frameErrCount + 1'b1;
				end
				if (carrier_present_n ||
					(framingError &&
					(frameErrCount == FE_LAST)) ||
					runExpired) begin
					next_state = ST_LOAD_HOLD;
					next_control_bits = cid_host_pkg::CTL_POWER_DOWN;
				end
			end
			ST_LOAD_HOLD: begin
				// Demod already off; loads drop when the hold window expires
				if (phaseExpired) begin
					next_state = ST_OFF;
					next_lineLoad = 1'b0;
					next_handsetMute = 1'b0;
					next_keypadEnable = 1'b1;
					next_sessionDone = 1'b1;
				end
			end
			default: begin
				next_state = ST_OFF;
				next_control_bits = cid_host_pkg::CTL_POWER_DOWN;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_OFF;
			control_bits <= cid_host_pkg::CTL_POWER_DOWN;
			lineLoad <= 1'b0;
			handsetMute <= 1'b0;
			keypadEnable <= 1'b1;
			ackRequest <= 1'b0;
			ackDigitA <= 1'b0;
			sessionDone <= 1'b0;
			attemptFailed <= 1'b0;
			busy <= 1'b0;
			frameErrCount <= '0;
			lastData <= 1'b1;
			lastToneFlag <= 1'b1;
		end else begin
			state <= next_state;
			control_bits <= next_control_bits;
			lineLoad <= next_lineLoad;
			handsetMute <= next_handsetMute;
			keypadEnable <= next_keypadEnable;
			ackRequest <= next_ackRequest;
			ackDigitA <= next_ackDigitA;
			sessionDone <= next_sessionDone;
			attemptFailed <= next_attemptFailed;
			busy <= (next_state != ST_OFF);
			frameErrCount <= next_frameErrCount;
			lastData <= serialData;
			lastToneFlag <= ready_or_tone_flag_n;
		end
	end
endmodule : caller_id_host_sequencer

/* dv/cid_host_props.sv */
// Port checker for the receiver sequencer
`timescale 1ns/100ps
module cid_host_props (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Orders and pins
	input wire logic ringActive,
	input wire logic displayServices,
	input wire logic ackDone,
	input wire logic carrier_present_n,
	input wire logic ready_or_tone_flag_n,
	input wire logic [cid_host_pkg::CTL_WIDTH-1:0] control_bits,
	// Line and handset
	input wire logic lineLoad,
	input wire logic handsetMute,
	input wire logic keypadEnable,
	input wire logic ackRequest,
	input wire logic ackDigitA,
	input wire logic attemptFailed,
	input wire logic busy
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	chk_carrier_exit: assert property ($rose(carrier_present_n) &&
		control_bits == 3'h1 |=> control_bits == 3'h0) else $error("no exit");
	chk_load_hold: assert property ($rose(carrier_present_n) &&
		control_bits == 3'h1 |=> lineLoad [*8]) else $error("load early");
	chk_ring_end: assert property ($fell(ringActive) && busy &&
		!lineLoad && control_bits == 3'h0 |=> lineLoad && control_bits == 3'h1)
		else $error("no load");
	chk_tone_mute: assert property ($fell(ready_or_tone_flag_n) &&
		control_bits[1] |=> handsetMute && !keypadEnable) else $error("mute");
	chk_tone_rise: assert property ($rose(ready_or_tone_flag_n) &&
		handsetMute && control_bits[1] |=> lineLoad && ackRequest &&
		control_bits == 3'h0) else $error("ack");
	chk_ack_digit: assert property (ackRequest |->
		ackDigitA == displayServices) else $error("digit");
	chk_ack_first: assert property (ackDone && handsetMute &&
		lineLoad && control_bits == 3'h0 |=> control_bits == 3'h1)
		else $error("no demod");
	chk_fail_clean: assert property (attemptFailed |->
		control_bits == 3'h0 && !lineLoad && !handsetMute && keypadEnable)
		else $error("fail state");
endmodule : cid_host_props
bind caller_id_host_sequencer cid_host_props chk (.*);

/* dv/cid_rx_model.sv */
// Behavioural model of the receiver chip
`timescale 1ns/100ps
module cid_rx_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Control and line state
	input wire logic [cid_host_pkg::CTL_WIDTH-1:0] control_bits,
	input wire logic fskOn,
	input wire logic toneOn,
	// Status pins
	output logic carrier_present_n,
	output logic ready_or_tone_flag_n
);
	// Ringing has no path to the flags
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			carrier_present_n <= 1'b1;
			ready_or_tone_flag_n <= 1'b1;
		end else begin
			carrier_present_n <= !(control_bits == 3'h1 && fskOn);
			ready_or_tone_flag_n <= !(control_bits[1] && toneOn);
		end
	end
endmodule : cid_rx_model

/* dv/caller_id_host_sequencer_test.sv */
// Self-checking bench for the receiver sequencer
`timescale 1ns/100ps
`define CHK(m, e, a) begin nChecks++; if ((a) !== (e)) begin errTotal++; \
	$display("BAD %s exp %0h got %0h", m, e, a); end end
`define WT(c, l) begin n = 0; while (!(c) && n < l) begin cyc(1); n++; end end
module caller_id_host_sequencer_test;
	logic sys_clk = 0, rst_n = 0, onHookStart = 0, offHookWatch = 0;
	logic lineSideAlert = 0, displayServices = 0, ackDone = 0, ringActive = 0;
	logic framingError = 0, serialData = 0, fskOn = 0, toneOn = 0, still = 0;
	logic carrier_present_n, ready_or_tone_flag_n, lineLoad, handsetMute;
	logic keypadEnable, ackRequest, ackDigitA, sessionDone, attemptFailed, busy;
	logic [cid_host_pkg::CTL_WIDTH-1:0] control_bits;
	int errTotal = 0, nChecks = 0;
	// Short counts keep the run brief
	caller_id_host_sequencer #(.RUN_LIMIT(200), .RX_TIMEOUT(400),
		.WAIT_D(400), .LOAD_HOLD(100)) uut (.*);
	cid_rx_model rx (.*);
	initial forever #2 sys_clk = ~sys_clk;
	always @(negedge sys_clk) if (!still) serialData <= ~serialData;
	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask : cyc
	task automatic closeOut();
		$display("checks %0d mismatches %0d", nChecks, errTotal);
		if (errTotal == 0 && nChecks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : closeOut
	task automatic noData();
		int n;
		`WT(attemptFailed === 1'b1, 1000)
		`CHK("toWin", 1'b1, n > 390 && n < 410)
		`CHK("noDone", 1'b0, sessionDone)
		cyc(1);
		`CHK("toCtl", 3'h0, control_bits)
		`CHK("toHs", 3'h1, {lineLoad, handsetMute, keypadEnable})
	endtask : noData
	task automatic dataPhase(input int mode);
		int n;
		still = mode == 2;
		fskOn = 1;
		cyc(4);
		`CHK("carrierLow", 1'b0, carrier_present_n)
		if (mode == 1) begin
			repeat (5) begin
				`CHK("feHold", 3'h1, control_bits)
				framingError = 1;
				cyc(1);
				framingError = 0;
				cyc(2);
			end
			`CHK("feExit", 3'h0, control_bits)
		end else if (mode == 2) begin
			`WT(control_bits !== 3'h1, 400)
			`CHK("runLen", 1'b1, n > 190 && n < 205)
		end else begin
			framingError = 1;
			cyc(1);
			framingError = 0;
			cyc(40);
			`CHK("feClear", 3'h1, control_bits)
		end
		fskOn = 0;
		`WT(control_bits === 3'h0, 10)
		`CHK("carrierExit", 1'b1, n < 4)
		`CHK("loadOn", 1'b1, lineLoad)
		`WT(busy === 1'b0, 300)
		if (mode == 0) `CHK("holdLen", 1'b1, n > 95 && n < 106)
		`CHK("done", 1'b1, sessionDone)
		`CHK("idle", 2'h0, {lineLoad, busy})
		still = 0;
	endtask : dataPhase
	task automatic onHook(input int mode);
		ringActive = 1;
		onHookStart = 1;
		cyc(1);
		onHookStart = 0;
		cyc(3);
		`CHK("ringOff", 3'h0, control_bits)
		ringActive = 0;
		cyc(2);
		`CHK("ringEnd", 4'h9, {lineLoad, control_bits})
		if (mode < 0) noData();
		else dataPhase(mode);
		$display("onHook %0d done", mode);
	endtask : onHook
	task automatic offHook(input logic ds, input logic data);
		int n;
		lineSideAlert = ds;
		displayServices = ds;
		offHookWatch = 1;
		cyc(1);
		offHookWatch = 0;
		cyc(1);
		`CHK("alert", {2'h1, ds}, control_bits)
		toneOn = 1;
		cyc(4);
		`CHK("mute", 2'h2, {handsetMute, keypadEnable})
		toneOn = 0;
		`WT(ackRequest === 1'b1, 20)
		`CHK("digit", ds, ackDigitA)
		`CHK("ackLoad", 4'h8, {lineLoad, control_bits})
		cyc(5);
		`CHK("ackWait", 3'h0, control_bits)
		ackDone = 1;
		cyc(1);
		ackDone = 0;
		cyc(1);
		`CHK("ackDemod", 3'h1, control_bits)
		if (data) dataPhase(0);
		else noData();
		$display("offHook %0d done", ds);
	endtask : offHook
	initial begin
		cyc(12);
		rst_n = 1;
		cyc(1);
		`CHK("rstCtl", 3'h0, control_bits)
		onHook(1);
		onHook(0);
		onHook(2);
		onHook(-1);
		offHook(1'b0, 1'b1);
		offHook(1'b1, 1'b0);
		closeOut();
	end
	initial begin
		#80000;
		errTotal++;
		closeOut();
	end
endmodule : caller_id_host_sequencer_test
